// ---- hdl/sfsr_pkg.sv ----
// sfsr_pkg: offsets, bit positions and constants of the sensor fault/status register bank
package sfsr_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_FAULT    = 8'h24;
    localparam logic [7:0]  OFS_ADVISORY = 8'h26;
    localparam logic [7:0]  OFS_TEMP     = 8'h28;
    localparam logic [7:0]  OFS_FIELD    = 8'h2A;
    localparam logic [7:0]  OFS_HYST     = 8'h30;
    localparam logic [7:0]  OFS_FINE     = 8'h32;
    localparam logic [7:0]  OFS_ZCROSS   = 8'h34;
    localparam logic [7:0]  OFS_UNLOCK   = 8'h3C;
    // fault register bits
    localparam int B_UVA      = 2;
    localparam int B_DIGUV    = 3;
    localparam int B_OSC      = 4;
    localparam int B_UNCORR   = 5;
    localparam int B_ZCTO     = 6;
    localparam int B_LOCK     = 7;
    localparam int B_QUAD     = 8;
    localparam int B_AVGF     = 9;
    localparam int B_SUMMARY  = 11;
    // advisory register bits
    localparam int B_STRONG   = 1;
    localparam int B_OVERLAP  = 2;
    localparam int B_CLIP     = 4;
    localparam int B_CORR     = 5;
    localparam int B_THERM    = 6;
    localparam int B_EXTFAIL  = 7;
    localparam int B_SLEW     = 8;
    localparam int B_CHKSUM   = 10;
    localparam int B_IFACE    = 11;
    // angle word bits
    localparam int B_PARITY   = 12;
    localparam int B_LOWSUP   = 13;
    localparam int B_EFLAG    = 14;
    // mask word: 24 bits, fault masks in 11:0, advisory masks spread above
    localparam int MASK_W     = 24;
    localparam logic [15:0] FAULT_IMPL  = 16'h07FF;
    localparam logic [15:0] ADV_IMPL    = 16'h0DF6;
    // unlock key field and sequence
    localparam int KEY_LSB    = 8;
    localparam logic [7:0]  KEY_0 = 8'h00;
    localparam logic [7:0]  KEY_1 = 8'h27;
    localparam logic [7:0]  KEY_2 = 8'h81;
    localparam logic [7:0]  KEY_3 = 8'h1F;
    localparam logic [7:0]  KEY_4 = 8'h77;
    // temperature clamp, eighths of a degree relative to 25 C (-60 C, 180 C)
    localparam logic signed [15:0] TEMP_MIN = -16'sd680;
    localparam logic signed [15:0] TEMP_MAX = 16'sd1240;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    typedef enum logic [2:0] {SFSR_K0, SFSR_K1, SFSR_K2, SFSR_K3, SFSR_K4} sfsr_key_t;
endpackage

// ---- hdl/sfsr_regs.sv ----
// sfsr_regs: latched fault/advisory words, measurement words, angle words and unlock key
module sfsr_regs (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register access port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata_q,
    // clear commands from the control word
    input  wire logic        clear_fault,
    input  wire logic        clear_advisory,
    // fault sources, bits 0..10; analog undervoltage feeds only the low supply bit of the angle words
    input  wire logic [10:0] fault_event,
    input  wire logic        digital_undervoltage,
    input  wire logic        analog_undervoltage,
    // advisory sources
    input  wire logic        strong_field_flag,
    input  wire logic        overlapping_access_flag,
    input  wire logic        clipping_flag,
    input  wire logic        corrected_memory_error,
    input  wire logic        extended_cmd_fail,
    input  wire logic        slew_limit_warning,
    input  wire logic        checksum_error,
    input  wire logic        bit_count_error,
    input  wire logic        data_bit15_error,
    input  wire logic        manchester_error,
    // measurements and configuration
    input  wire logic [23:0] mask_word,
    input  wire logic [15:0] temp_eighths,
    input  wire logic [11:0] field_gauss,
    input  wire logic [11:0] hyst_angle,
    input  wire logic [14:0] fine_angle,
    input  wire logic [11:0] zcross_angle,
    // status
    output logic             fault_summary_q,
    output logic             customer_unlocked_flag_q
);

    logic [15:0]             fault_q, fault_d, fault_seen_q, fault_seen_d;
    logic [15:0]             adv_q, adv_d, adv_seen_q, adv_seen_d;
    logic [15:0]             fault_set, adv_set, fmask, amask, fault_view, temp_word;
    logic [15:0]             rdata_d, hyst_word, zc_word;
    logic                    advisory_summary, low_supply_flag, eflag_d;
    logic                    unl_q, unl_d;
    sfsr_pkg::sfsr_key_t     key_q, key_d;
    logic [7:0]              key_in;
    logic signed [15:0]      temp_s, temp_c;

    // mask word spread onto register bit positions
    always_comb begin
        fmask = {4'h0, mask_word[11:0]};
        amask = {4'h0, mask_word[23:22], 1'b0, mask_word[20:16], 1'b0,
                 mask_word[14:13], 1'b0};
    end

    // temperature clamp
    always_comb begin
        temp_s = signed'(temp_eighths);
        if (temp_s < sfsr_pkg::TEMP_MIN) begin
            temp_c = sfsr_pkg::TEMP_MIN;
        end else if (temp_s > sfsr_pkg::TEMP_MAX) begin
            temp_c = sfsr_pkg::TEMP_MAX;
        end else begin
            temp_c = temp_s;
        end
        temp_word = {4'h0, temp_c[11:0]};
    end

    // event sources
    always_comb begin
        fault_set = {5'h00, fault_event};
        fault_set[sfsr_pkg::B_DIGUV] = fault_event[sfsr_pkg::B_DIGUV]
                                     | digital_undervoltage;
        adv_set = 16'h0000;
        adv_set[sfsr_pkg::B_STRONG]  = strong_field_flag;
        adv_set[sfsr_pkg::B_OVERLAP] = overlapping_access_flag;
        adv_set[sfsr_pkg::B_CLIP]    = clipping_flag;
        adv_set[sfsr_pkg::B_CORR]    = corrected_memory_error;
        adv_set[sfsr_pkg::B_THERM]   = (temp_s < sfsr_pkg::TEMP_MIN)
                                     | (temp_s > sfsr_pkg::TEMP_MAX);
        adv_set[sfsr_pkg::B_EXTFAIL] = extended_cmd_fail;
        adv_set[sfsr_pkg::B_SLEW]    = slew_limit_warning;
        adv_set[sfsr_pkg::B_CHKSUM]  = checksum_error;
        adv_set[sfsr_pkg::B_IFACE]   = bit_count_error | data_bit15_error
                                     | manchester_error;
    end

    // summaries are live so a masked bit never shows
    always_comb begin
        advisory_summary = |(adv_q & ~amask) & ~fmask[sfsr_pkg::B_SUMMARY];
        fault_view = fault_q;
        fault_view[sfsr_pkg::B_SUMMARY] = advisory_summary;
        low_supply_flag = (analog_undervoltage & ~fmask[sfsr_pkg::B_UVA])
                        | (digital_undervoltage & ~fmask[sfsr_pkg::B_DIGUV]);
        eflag_d = (|(fault_view & ~fmask)) | (|(adv_q & ~amask));
    end

    // latches: set wins over clear, and a clear only removes bits already read
    always_comb begin
        fault_seen_d = fault_seen_q;
        adv_seen_d   = adv_seen_q;
        fault_d      = fault_q;
        adv_d        = adv_q;
        if (clear_fault) begin
            fault_d      = fault_q & ~fault_seen_q;
            fault_seen_d = 16'h0000;
        end
        if (clear_advisory) begin
            adv_d      = adv_q & ~adv_seen_q;
            adv_seen_d = 16'h0000;
        end
        if (reg_rd && reg_addr == sfsr_pkg::OFS_FAULT) begin
            fault_seen_d = fault_q;
        end
        if (reg_rd && reg_addr == sfsr_pkg::OFS_ADVISORY) begin
            adv_seen_d = adv_q;
        end
        fault_d = (fault_d | fault_set) & sfsr_pkg::FAULT_IMPL;
        adv_d   = (adv_d | adv_set) & sfsr_pkg::ADV_IMPL;
    end

    // angle words with masked undervoltage, error flag and odd parity
    always_comb begin
        hyst_word = {1'b0, eflag_d, low_supply_flag, 1'b0, hyst_angle};
        hyst_word[sfsr_pkg::B_PARITY] = ~(^hyst_word);
        zc_word = {1'b0, eflag_d, low_supply_flag, 1'b0, zcross_angle};
        zc_word[sfsr_pkg::B_PARITY] = ~(^zc_word);
    end

    // unlock key sequence; any wrong value restarts, a lone 0x00 counts as first
    always_comb begin
        key_in = reg_wdata[sfsr_pkg::KEY_LSB +: 8];
        key_d  = key_q;
        unl_d  = unl_q;
        if (reg_wr && reg_addr == sfsr_pkg::OFS_UNLOCK) begin
            case (key_q)
                sfsr_pkg::SFSR_K0: key_d = (key_in == sfsr_pkg::KEY_0) ? sfsr_pkg::SFSR_K1
                                                                   : sfsr_pkg::SFSR_K0;
                sfsr_pkg::SFSR_K1: key_d = (key_in == sfsr_pkg::KEY_1) ? sfsr_pkg::SFSR_K2
                                        : (key_in == sfsr_pkg::KEY_0) ? sfsr_pkg::SFSR_K1
                                                                   : sfsr_pkg::SFSR_K0;
                sfsr_pkg::SFSR_K2: key_d = (key_in == sfsr_pkg::KEY_2) ? sfsr_pkg::SFSR_K3
                                        : (key_in == sfsr_pkg::KEY_0) ? sfsr_pkg::SFSR_K1
                                                                   : sfsr_pkg::SFSR_K0;
                sfsr_pkg::SFSR_K3: key_d = (key_in == sfsr_pkg::KEY_3) ? sfsr_pkg::SFSR_K4
                                        : (key_in == sfsr_pkg::KEY_0) ? sfsr_pkg::SFSR_K1
                                                                   : sfsr_pkg::SFSR_K0;
                sfsr_pkg::SFSR_K4: begin
                    key_d = (key_in == sfsr_pkg::KEY_0) ? sfsr_pkg::SFSR_K1 : sfsr_pkg::SFSR_K0;
                    if (key_in == sfsr_pkg::KEY_4) begin
                        unl_d = 1'b1;
                    end
                end
                default: key_d = sfsr_pkg::SFSR_K0;
            endcase
        end
    end

    // read mux, answered on the edge after the read strobe
    always_comb begin
        rdata_d = reg_rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                sfsr_pkg::OFS_FAULT:    rdata_d = fault_view;
                sfsr_pkg::OFS_ADVISORY: rdata_d = adv_q;
                sfsr_pkg::OFS_TEMP:     rdata_d = temp_word;
                sfsr_pkg::OFS_FIELD:    rdata_d = {4'h0, field_gauss};
                sfsr_pkg::OFS_HYST:     rdata_d = hyst_word;
                sfsr_pkg::OFS_FINE:     rdata_d = {1'b0, fine_angle};
                sfsr_pkg::OFS_ZCROSS:   rdata_d = zc_word;
                sfsr_pkg::OFS_UNLOCK:   rdata_d = {15'h0000, unl_q};
                default:                rdata_d = sfsr_pkg::RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_q                  <= sfsr_pkg::RESET_WORD;
            fault_seen_q             <= sfsr_pkg::RESET_WORD;
            adv_q                    <= sfsr_pkg::RESET_WORD;
            adv_seen_q               <= sfsr_pkg::RESET_WORD;
            reg_rdata_q              <= sfsr_pkg::RESET_WORD;
            key_q                    <= sfsr_pkg::SFSR_K0;
            unl_q                    <= 1'b0;
            fault_summary_q          <= 1'b0;
            customer_unlocked_flag_q <= 1'b0;
        end else begin
            fault_q                  <= fault_d;
            fault_seen_q             <= fault_seen_d;
            adv_q                    <= adv_d;
            adv_seen_q               <= adv_seen_d;
            reg_rdata_q              <= rdata_d;
            key_q                    <= key_d;
            unl_q                    <= unl_d;
            fault_summary_q          <= eflag_d;
            customer_unlocked_flag_q <= unl_d;
        end
    end

    // checks
    AST_DIGUV_SET: assert property (@(posedge ref_clk) disable iff (rst)
        digital_undervoltage |=> fault_q[sfsr_pkg::B_DIGUV])
        else $error("undervoltage not latched");
    AST_OSC_SET: assert property (@(posedge ref_clk) disable iff (rst)
        fault_event[sfsr_pkg::B_OSC] |=> fault_q[sfsr_pkg::B_OSC])
        else $error("oscillator fault not latched");
    AST_LOCK_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        fault_q[sfsr_pkg::B_LOCK] && !clear_fault |=> fault_q[sfsr_pkg::B_LOCK])
        else $error("lock loss dropped without clear");
    AST_UNREAD_SURVIVES: assert property (@(posedge ref_clk) disable iff (rst)
        clear_fault && !fault_seen_q[sfsr_pkg::B_AVGF] && fault_q[sfsr_pkg::B_AVGF]
        |=> fault_q[sfsr_pkg::B_AVGF])
        else $error("unread fault cleared");
    AST_ADV_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
        clear_advisory && adv_seen_q[sfsr_pkg::B_CLIP] && !clipping_flag
        |=> !adv_q[sfsr_pkg::B_CLIP])
        else $error("read advisory not cleared");
    AST_IFACE_SET: assert property (@(posedge ref_clk) disable iff (rst)
        (bit_count_error || manchester_error) |=> adv_q[sfsr_pkg::B_IFACE])
        else $error("interface fault not latched");
    AST_PARITY: assert property (@(posedge ref_clk) disable iff (rst)
        $past(reg_rd) && ($past(reg_addr) == sfsr_pkg::OFS_HYST) |-> ^reg_rdata_q)
        else $error("angle word parity even");
    AST_SUMMARY_MASK: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_FAULT && mask_word[sfsr_pkg::B_SUMMARY]
        |=> !reg_rdata_q[sfsr_pkg::B_SUMMARY])
        else $error("masked summary bit visible");
    AST_TEMP_CLAMP: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_TEMP && signed'(temp_eighths) > sfsr_pkg::TEMP_MAX
        |=> reg_rdata_q == {4'h0, sfsr_pkg::TEMP_MAX[11:0]} && adv_q[sfsr_pkg::B_THERM])
        else $error("temperature not clamped");
    AST_KEY_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_UNLOCK |=> reg_rdata_q[15:1] == 15'h0000)
        else $error("key field reads nonzero");

    AST_UNCORR_SET: assert property (@(posedge ref_clk) disable iff (rst)
        fault_event[sfsr_pkg::B_UNCORR] |=> fault_q[sfsr_pkg::B_UNCORR])
        else $error("memory fault not latched");

    AST_ZCTO_SET: assert property (@(posedge ref_clk) disable iff (rst)
        fault_event[sfsr_pkg::B_ZCTO] |=> fault_q[sfsr_pkg::B_ZCTO])
        else $error("zero crossing timeout not latched");

    AST_QUAD_SET: assert property (@(posedge ref_clk) disable iff (rst)
        fault_event[sfsr_pkg::B_QUAD] |=> fault_q[sfsr_pkg::B_QUAD])
        else $error("encoder fault not latched");

    AST_AVGF_SET: assert property (@(posedge ref_clk) disable iff (rst)
        fault_event[sfsr_pkg::B_AVGF] |=> fault_q[sfsr_pkg::B_AVGF])
        else $error("averaging fault not latched");

    AST_STRONG_SET: assert property (@(posedge ref_clk) disable iff (rst)
        strong_field_flag |=> adv_q[sfsr_pkg::B_STRONG])
        else $error("strong field not latched");

    AST_OVERLAP_SET: assert property (@(posedge ref_clk) disable iff (rst)
        overlapping_access_flag |=> adv_q[sfsr_pkg::B_OVERLAP])
        else $error("overlapping access not latched");

    AST_CLIP_SET: assert property (@(posedge ref_clk) disable iff (rst)
        clipping_flag |=> adv_q[sfsr_pkg::B_CLIP])
        else $error("clipping not latched");

    AST_CORR_SET: assert property (@(posedge ref_clk) disable iff (rst)
        corrected_memory_error |=> adv_q[sfsr_pkg::B_CORR])
        else $error("corrected memory error not latched");

    AST_EXTFAIL_SET: assert property (@(posedge ref_clk) disable iff (rst)
        extended_cmd_fail |=> adv_q[sfsr_pkg::B_EXTFAIL])
        else $error("extended command failure not latched");

    AST_SLEW_SET: assert property (@(posedge ref_clk) disable iff (rst)
        slew_limit_warning |=> adv_q[sfsr_pkg::B_SLEW])
        else $error("slew warning not latched");

    AST_CHKSUM_SET: assert property (@(posedge ref_clk) disable iff (rst)
        checksum_error |=> adv_q[sfsr_pkg::B_CHKSUM])
        else $error("checksum error not latched");

    AST_BIT15_SET: assert property (@(posedge ref_clk) disable iff (rst)
        data_bit15_error |=> adv_q[sfsr_pkg::B_IFACE])
        else $error("data bit 15 error not latched");

    AST_TEMP_PASS: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_TEMP && !adv_set[sfsr_pkg::B_THERM]
        |=> reg_rdata_q == ($past(temp_eighths) & 16'h0FFF))
        else $error("temperature word altered");

    AST_TEMP_FLOOR: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_TEMP && signed'(temp_eighths) < sfsr_pkg::TEMP_MIN
        |=> reg_rdata_q == {4'h0, sfsr_pkg::TEMP_MIN[11:0]} && adv_q[sfsr_pkg::B_THERM])
        else $error("temperature not clamped low");

    AST_HYSTERESIS_ANGLE_WORD_ANGLE: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_HYST |=> reg_rdata_q[11:0] == $past(hyst_angle))
        else $error("hysteresis angle wrong");

    AST_ZC_ANGLE: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_ZCROSS |=> reg_rdata_q[11:0] == $past(zcross_angle))
        else $error("zero crossing angle wrong");

    AST_ZC_PARITY: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_ZCROSS |=> ^reg_rdata_q)
        else $error("zero crossing parity even");

    AST_LOWSUP_BIT: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_HYST && analog_undervoltage
        && !mask_word[sfsr_pkg::B_UVA] |=> reg_rdata_q[sfsr_pkg::B_LOWSUP])
        else $error("low supply bit missing");

    AST_EFLAG_BIT: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_HYST && mask_word == 24'h00_0000
        && fault_q != 16'h0000 |=> reg_rdata_q[sfsr_pkg::B_EFLAG])
        else $error("error flag missing");

    AST_ADV_SURVIVES: assert property (@(posedge ref_clk) disable iff (rst)
        clear_advisory && !adv_seen_q[sfsr_pkg::B_CLIP] && adv_q[sfsr_pkg::B_CLIP]
        |=> adv_q[sfsr_pkg::B_CLIP])
        else $error("unread advisory cleared");

    AST_UNLOCK_STICKY: assert property (@(posedge ref_clk) disable iff (rst)
        customer_unlocked_flag_q |=> customer_unlocked_flag_q)
        else $error("unlock dropped without reset");
    COV_UNLOCK: cover property (@(posedge ref_clk) disable iff (rst)
        !customer_unlocked_flag_q ##1 customer_unlocked_flag_q);
    COV_READ_CLEAR: cover property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_FAULT && fault_q != 16'h0000 ##[1:4] clear_fault);
    COV_SUMMARY: cover property (@(posedge ref_clk) disable iff (rst) fault_summary_q);
    COV_UNREAD_KEPT: cover property (@(posedge ref_clk) disable iff (rst)
        clear_fault && !fault_seen_q[sfsr_pkg::B_AVGF] && fault_q[sfsr_pkg::B_AVGF]);
    COV_CLAMP: cover property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == sfsr_pkg::OFS_TEMP && adv_set[sfsr_pkg::B_THERM]);

endmodule

// ---- tb/sfsr_host_model.sv ----
// sfsr_host_model: host side issuing register reads, key writes and clear commands
module sfsr_host_model (
    // clock
    input  wire logic        ref_clk,
    // register access
    output logic      [7:0]  reg_addr,
    output logic             reg_rd,
    output logic             reg_wr,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata_q,
    // clear commands
    output logic             clear_fault,
    output logic             clear_advisory
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        clear_fault = 1'b0;
        clear_advisory = 1'b0;
    end
    // strobes move on the falling edge; released lines flip so stale values never linger
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_q;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic clr(input logic f, input logic w);
        @(negedge ref_clk);
        clear_fault = f;
        clear_advisory = w;
        @(negedge ref_clk);
        clear_fault = 1'b0;
        clear_advisory = 1'b0;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the sensor fault/status register bank
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr;
    logic        reg_rd, reg_wr, clear_fault, clear_advisory;
    logic [15:0] reg_wdata, reg_rdata_q;
    logic [10:0] fault_event = '0;
    logic [9:0]  adv_src = '0;
    logic        digital_undervoltage = 1'b0;
    logic        analog_undervoltage = 1'b0;
    logic [23:0] mask_word = '0;
    logic [15:0] temp_eighths = '0;
    logic [11:0] field_gauss = '0;
    logic [11:0] hyst_angle = '0;
    logic [11:0] zcross_angle = '0;
    logic [14:0] fine_angle = '0;
    logic        fault_summary_q, customer_unlocked_flag_q;
    logic [31:0] seed = 32'ha52c_abac;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          adv_bit[10] = '{1, 2, 4, 5, 7, 8, 10, 11, 11, 11};
    int          adv_msk[10] = '{13, 14, 16, 17, 19, 20, 22, 23, 23, 23};
    logic [15:0] tc[4] = '{16'hfd58, 16'hfd57, 16'h04d8, 16'h04d9};
    logic [7:0]  key[5] = '{8'h00, 8'h27, 8'h81, 8'h1f, 8'h77};

    sfsr_regs sfsr_regs_i (.ref_clk, .rst, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
        .reg_rdata_q, .clear_fault, .clear_advisory, .fault_event, .digital_undervoltage,
        .analog_undervoltage, .strong_field_flag(adv_src[0]), .overlapping_access_flag(adv_src[1]),
        .clipping_flag(adv_src[2]), .corrected_memory_error(adv_src[3]),
        .extended_cmd_fail(adv_src[4]), .slew_limit_warning(adv_src[5]),
        .checksum_error(adv_src[6]), .bit_count_error(adv_src[7]), .data_bit15_error(adv_src[8]),
        .manchester_error(adv_src[9]), .mask_word, .temp_eighths, .field_gauss, .hyst_angle,
        .fine_angle, .zcross_angle, .fault_summary_q, .customer_unlocked_flag_q);
    sfsr_host_model sfsr_host_model_i (.ref_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
        .reg_rdata_q, .clear_fault, .clear_advisory);

    always #10 ref_clk = ~ref_clk;
    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // parity bit makes the whole word odd
    function automatic logic [15:0] angw(logic [11:0] a, logic ef, logic uv);
        return {1'b0, ef, uv, ~^{ef, uv, a}, a};
    endfunction
    // -60 C and 180 C in eighths relative to 25 C
    function automatic logic [15:0] tempw(logic signed [15:0] t);
        logic signed [15:0] c;
        c = (t < -16'sd680) ? -16'sd680 : (t > 16'sd1240) ? 16'sd1240 : t;
        return {4'h0, c[11:0]};
    endfunction
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e, input string n);
        logic [15:0] d;
        sfsr_host_model_i.rd(a, d);
        `CHK(n, e, d)
    endtask
    task automatic ev(input logic [10:0] f, input logic [9:0] a);
        @(negedge ref_clk);
        fault_event = f;
        adv_src = a;
        @(negedge ref_clk);
        fault_event = '0;
        adv_src = '0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        logic signed [15:0] t;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        chk_rd(8'h24, 16'h0000, "fault after reset");
        chk_rd(8'h26, 16'h0000, "advisory after reset");
        for (int b = 0; b < 11; b++) begin
            ev(11'h001 << b, '0);
            chk_rd(8'h24, 16'h0001 << b, "fault bit");
            `CHK("summary out", 1'b1, fault_summary_q)
            sfsr_host_model_i.clr(1'b1, 1'b0);
            chk_rd(8'h24, 16'h0000, "fault cleared");
        end
        ev(11'h210, 10'h004);
        sfsr_host_model_i.clr(1'b1, 1'b1);
        chk_rd(8'h24, 16'h0a10, "unread fault kept");
        chk_rd(8'h26, 16'h0010, "unread advisory kept");
        sfsr_host_model_i.clr(1'b1, 1'b1);
        chk_rd(8'h24, 16'h0000, "read fault cleared");
        chk_rd(8'h26, 16'h0000, "read advisory cleared");
        digital_undervoltage = 1'b1;
        chk_rd(8'h24, 16'h0008, "undervoltage");
        sfsr_host_model_i.clr(1'b1, 1'b0);
        chk_rd(8'h24, 16'h0008, "undervoltage re-set");
        chk_rd(8'h30, angw(hyst_angle, 1'b1, 1'b1), "uv live");
        mask_word = 24'h00_0008;
        chk_rd(8'h30, angw(hyst_angle, 1'b0, 1'b0), "uv masked");
        digital_undervoltage = 1'b0;
        mask_word = '0;
        sfsr_host_model_i.clr(1'b1, 1'b0);
        $display("test faults done");
        for (int i = 0; i < 10; i++) begin
            ev('0, 10'h001 << i);
            chk_rd(8'h26, 16'h0001 << adv_bit[i], "advisory bit");
            chk_rd(8'h24, 16'h0800, "advisory summary");
            mask_word = 24'h00_0800;
            chk_rd(8'h24, 16'h0000, "summary masked");
            mask_word = 24'h00_0001 << adv_msk[i];
            chk_rd(8'h34, angw(zcross_angle, 1'b0, 1'b0), "error flag masked");
            `CHK("summary out masked", 1'b0, fault_summary_q)
            mask_word = '0;
            sfsr_host_model_i.clr(1'b0, 1'b1);
            chk_rd(8'h26, 16'h0000, "advisory cleared");
        end
        $display("test advisories done");
        for (int i = 0; i < 12; i++) begin
            void'(xs());
            t = seed[15:0];
            temp_eighths = (i < 4) ? tc[i] : {{4{t[11]}}, t[11:0]};
            t = temp_eighths;
            chk_rd(8'h28, tempw(t), "temperature");
            chk_rd(8'h26, (t < -680 || t > 1240) ? 16'h0040 : 16'h0000, "thermal flag");
            temp_eighths = '0;
            chk_rd(8'h28, 16'h0000, "temperature zero");
            sfsr_host_model_i.clr(1'b0, 1'b1);
        end
        $display("test temperature done");
        for (int i = 0; i < 8; i++) begin
            void'(xs());
            hyst_angle = (i == 0) ? 12'hfff : seed[11:0];
            zcross_angle = seed[23:12];
            fine_angle = seed[30:16];
            field_gauss = seed[27:16];
            analog_undervoltage = seed[31];
            chk_rd(8'h30, angw(hyst_angle, 1'b0, seed[31]), "hyst word");
            chk_rd(8'h34, angw(zcross_angle, 1'b0, seed[31]), "zcross word");
            chk_rd(8'h32, {1'b0, fine_angle}, "fine word");
            chk_rd(8'h2a, {4'h0, field_gauss}, "field word");
        end
        analog_undervoltage = 1'b0;
        $display("test angles done");
        sfsr_host_model_i.wr(8'h24, 16'hffff);
        chk_rd(8'h24, 16'h0000, "read-only fault");
        chk_rd(8'h2e, 16'h0000, "unmapped read");
        for (int i = 0; i < 4; i++) sfsr_host_model_i.wr(8'h3c, {key[i], 8'h00});
        sfsr_host_model_i.wr(8'h3c, 16'h5500);
        `CHK("still locked", 1'b0, customer_unlocked_flag_q)
        for (int i = 0; i < 5; i++) sfsr_host_model_i.wr(8'h3c, {key[i], 8'h00});
        `CHK("unlocked", 1'b1, customer_unlocked_flag_q)
        chk_rd(8'h3c, 16'h0001, "key readback");
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        `CHK("locked by reset", 1'b0, customer_unlocked_flag_q)
        $display("test unlock done");
        close_out();
    end
endmodule
